// ===== hw/serial_command_dispatch_consts.vh
// Constants for the serial command dispatcher: register map offsets,
// command codes, header flag positions, reset values and link operations.
// Assumes it is included by bare name from the design files.
`ifndef SERIAL_COMMAND_DISPATCH_CONSTS_VH
`define SERIAL_COMMAND_DISPATCH_CONSTS_VH

// Header byte flags.
`define HDR_AC_BIT        7
`define HDR_RW_BIT        6

// Register map offsets.
`define ADDR_CLK_CTRL1    8'h00
`define ADDR_CLK_CTRL0    8'h01
`define ADDR_INT_MASK0    8'h04
`define ADDR_ACK_RSSI_HI  8'h0b
`define ADDR_ACK_RSSI_LO  8'h0c
`define ADDR_COMMAND      8'h0f
`define ADDR_ACS_BASE     8'h80
`define ADDR_LBT_THRESH   8'hb0
`define ADDR_RSSI_NOW     8'hb5
`define ADDR_CHIP_ID_HI   8'hfd
`define ADDR_CHIP_ID_LO   8'hfe
`define ADDR_SILICON_REV  8'hff

// Reset values: the two non-zero defaults, and zero for every other register held in storage.
`define CLK_CTRL1_RST     8'h66
`define CLK_CTRL0_RST     8'h09
`define ZERO_RST          8'h00

// Field positions.
`define TIMER_CLK_SEL_BIT 1
`define MASK_RX_READY_BIT 5
`define MASK_TX_READY_BIT 4

// Command codes.
`define CMD_WAKE          8'h08
`define CMD_WAKE_CLIENT   8'h09
`define CMD_WAKE_MASTER   8'h0a
`define CMD_PAIR          8'h0c
`define CMD_ABORT         8'h80
`define CMD_HOST_STANDBY  8'h03
`define CMD_HOST_RX       8'h04
`define CMD_HOST_TX       8'h05
`define CMD_HOST_WAKE     8'h06
`define CMD_HOST_SLEEP    8'h07
`define CMD_TEMP_PAIR     8'h0f
`define CMD_SEND_INFO     8'h10
`define CMD_REGMAP_DFLT   8'hff

// Link manager operation codes.
`define LINK_WAKE         3'h0
`define LINK_WAKE_CLIENT  3'h1
`define LINK_WAKE_MASTER  3'h2
`define LINK_PAIR         3'h3
`define LINK_TEMP_PAIR    3'h4
`define LINK_SEND_INFO    3'h5

`endif

// ===== hw/regmap_store.v
// Register map storage: 256 bytes, one write port, two read ports.
// Assumes the caller arbitrates writes; read data appear one clock later.
`timescale 1ns/1ps
`default_nettype none

module regmap_store (
	// Clock.
	input  wire       clk,
	// Write port.
	input  wire       wr_en,
	input  wire [7:0] wr_addr,
	input  wire [7:0] wr_data,
	// Host read port.
	input  wire [7:0] rd_addr_a,
	output reg  [7:0] rd_data_a,
	// Channel list read port.
	input  wire [7:0] rd_addr_b,
	output reg  [7:0] rd_data_b
);

	reg [7:0] mem [0:255];

	// Write, then registered reads on both ports.
	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_a <= mem[rd_addr_a];
		rd_data_b <= mem[rd_addr_b];
	end

endmodule

`default_nettype wire

// ===== hw/serial_command_dispatch.v
// Serial command dispatcher: serial slave, register map decode and the
// command state machine of the transceiver core.
// Assumes serial pins are asynchronous and the radio side shares clk.
`timescale 1ns/1ps
`default_nettype none
`include "serial_command_dispatch_consts.vh"

module serial_command_dispatch #(
	parameter [7:0]  SILICON_REVISION = 8'h01, // Arbitrary value.
	parameter [15:0] CHIP_IDENT       = 16'h0000 // Arbitrary value.
) (
	// Clock and reset.
	input  wire        clk,
	input  wire        rst,
	// Serial host pins.
	input  wire        cs_n,
	input  wire        sclk,
	input  wire        mosi,
	output reg         miso_out,
	output reg         miso_oe,
	// Radio and link manager status.
	input  wire        rx_complete,
	input  wire        tx_complete,
	input  wire        link_done,
	input  wire        link_ok,
	input  wire [7:0]  rssi_now,
	input  wire        ack_rssi_load,
	input  wire [15:0] ack_rssi_value,
	input  wire [3:0]  acs_index,
	// Power and mode control.
	output reg         xtal_enable,
	output reg         sleep_active,
	output reg         timer_clk_sel,
	output reg         rx_enable,
	output reg         tx_enable,
	output reg         abort_pulse,
	// Link manager control.
	output reg         link_start,
	output reg  [2:0]  link_cmd,
	output reg         pair_store,
	output reg         paired,
	// Completion events and table values.
	output reg         rx_done_irq,
	output reg         tx_done_irq,
	output reg  [7:0]  lbt_threshold,
	output wire [7:0]  acs_channel
);

	localparam [5:0] ST_CLEAR   = 6'b000001;
	localparam [5:0] ST_STANDBY = 6'b000010;
	localparam [5:0] ST_SLEEP   = 6'b000100;
	localparam [5:0] ST_RX      = 6'b001000;
	localparam [5:0] ST_TX      = 6'b010000;
	localparam [5:0] ST_LINK    = 6'b100000;

	localparam [2:0] PH_HDR  = 3'b001;
	localparam [2:0] PH_ADDR = 3'b010;
	localparam [2:0] PH_DATA = 3'b100;

	// Default of the clock control byte, kept whole so one field can be picked out.
	localparam [7:0] CLK1_DEFAULT = `CLK_CTRL1_RST;

	reg  [5:0]  state_reg;
	reg  [7:0]  sweep_reg;
	reg         cs_s1, cs_s2, cs_s3;
	reg         sclk_s1, sclk_s2, sclk_s3;
	reg         mosi_s1, mosi_s2;
	reg  [2:0]  phase_reg;
	reg  [2:0]  bit_reg;
	reg  [7:0]  shift_reg;
	reg         is_cmd_reg;
	reg         is_read_reg;
	reg         cmd_have_reg;
	reg  [7:0]  cmd_byte_reg;
	reg  [7:0]  addr_reg;
	reg  [7:0]  miso_shift_reg;
	reg         load_pending_reg;
	reg  [7:0]  mask_reg;
	reg  [15:0] ack_rssi_reg;
	reg         info_pending_reg;
	reg         mem_we;
	reg  [7:0]  mem_waddr;
	reg  [7:0]  mem_wdata;
	reg  [7:0]  rd_value;
	reg         cmd_valid;
	reg  [7:0]  cmd_code;
	wire [7:0]  mem_rdata;
	wire        sclk_rise = sclk_s2 & ~sclk_s3;
	wire        sclk_fall = ~sclk_s2 & sclk_s3;
	wire        cs_active = ~cs_s2;
	wire        cs_release = cs_s2 & ~cs_s3;
	wire [7:0]  byte_in = {shift_reg[6:0], mosi_s2};
	wire        byte_done = cs_active & sclk_rise & (bit_reg == 3'h7);
	wire        host_write = byte_done & (phase_reg == PH_DATA) & ~is_read_reg & ~is_cmd_reg;
	wire        read_only = (addr_reg == `ADDR_SILICON_REV) | (addr_reg == `ADDR_CHIP_ID_HI) |
	                        (addr_reg == `ADDR_CHIP_ID_LO) | (addr_reg == `ADDR_ACK_RSSI_HI) |
	                        (addr_reg == `ADDR_ACK_RSSI_LO) | (addr_reg == `ADDR_RSSI_NOW);

	// Register map storage; the channel list port reads the switching table.
	regmap_store u_store (
		.clk       (clk),
		.wr_en     (mem_we),
		.wr_addr   (mem_waddr),
		.wr_data   (mem_wdata),
		.rd_addr_a (addr_reg),
		.rd_data_a (mem_rdata),
		.rd_addr_b (`ADDR_ACS_BASE | {4'h0, acs_index}),
		.rd_data_b (acs_channel)
	);

	// Two-flop synchronisers for the asynchronous serial pins.
	always @(posedge clk) begin
		if (rst) begin
			cs_s1   <= 1'b1;
			cs_s2   <= 1'b1;
			cs_s3   <= 1'b1;
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			mosi_s1 <= 1'b0;
			mosi_s2 <= 1'b0;
		end else begin
			cs_s1   <= cs_n;
			cs_s2   <= cs_s1;
			cs_s3   <= cs_s2;
			sclk_s1 <= sclk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			mosi_s1 <= mosi;
			mosi_s2 <= mosi_s1;
		end
	end

	// Storage write port: default sweep first, otherwise host writes.
	always @* begin
		mem_we    = 1'b0;
		mem_waddr = addr_reg;
		mem_wdata = byte_in;
		if (state_reg == ST_CLEAR) begin
			mem_we    = 1'b1;
			mem_waddr = sweep_reg;
			if (sweep_reg == `ADDR_CLK_CTRL1) begin
				mem_wdata = `CLK_CTRL1_RST;
			end else if (sweep_reg == `ADDR_CLK_CTRL0) begin
				mem_wdata = `CLK_CTRL0_RST;
			end else begin
				mem_wdata = `ZERO_RST;
			end
		end else if (host_write & ~read_only & (addr_reg != `ADDR_COMMAND)) begin
			mem_we = 1'b1;
		end
	end

	// Read data for the host, with live and read-only locations overlaid.
	always @* begin
		case (addr_reg)
			`ADDR_SILICON_REV: rd_value = SILICON_REVISION;
			`ADDR_CHIP_ID_HI:  rd_value = CHIP_IDENT[15:8];
			`ADDR_CHIP_ID_LO:  rd_value = CHIP_IDENT[7:0];
			`ADDR_ACK_RSSI_HI: rd_value = ack_rssi_reg[15:8];
			`ADDR_ACK_RSSI_LO: rd_value = ack_rssi_reg[7:0];
			`ADDR_RSSI_NOW:    rd_value = rssi_now;
			default:           rd_value = mem_rdata;
		endcase
	end

	// Serial slave: header, address, data with auto increment.
	always @(posedge clk) begin
		if (rst | ~cs_active) begin
			phase_reg        <= PH_HDR;
			bit_reg          <= 3'h0;
			shift_reg        <= 8'h00;
			load_pending_reg <= 1'b0;
			miso_oe          <= 1'b0;
			miso_out         <= 1'b0;
			miso_shift_reg   <= 8'h00;
			if (rst) begin
				is_cmd_reg   <= 1'b0;
				is_read_reg  <= 1'b0;
				cmd_have_reg <= 1'b0;
				cmd_byte_reg <= 8'h00;
				addr_reg     <= 8'h00;
			end else if (cs_release) begin
				cmd_have_reg <= 1'b0;
			end
		end else begin
			if (sclk_rise) begin
				shift_reg <= byte_in;
				bit_reg   <= bit_reg + 3'h1;
			end
			if (byte_done) begin
				case (phase_reg)
					PH_HDR: begin
						is_cmd_reg  <= byte_in[`HDR_AC_BIT];
						is_read_reg <= byte_in[`HDR_RW_BIT];
						phase_reg   <= (byte_in[`HDR_AC_BIT] & ~byte_in[`HDR_RW_BIT]) ? PH_DATA : PH_ADDR;
						cmd_have_reg <= 1'b0;
					end
					PH_ADDR: begin
						addr_reg         <= byte_in;
						phase_reg        <= PH_DATA;
						load_pending_reg <= is_read_reg;
					end
					PH_DATA: begin
						if (is_cmd_reg) begin
							cmd_byte_reg <= byte_in;
							cmd_have_reg <= ~is_read_reg;
						end else begin
							addr_reg         <= addr_reg + 8'h01;
							load_pending_reg <= is_read_reg;
						end
					end
					default: phase_reg <= PH_HDR;
				endcase
			end
			// Read data go out MSB first, changing on the falling edge.
			if (sclk_fall & (phase_reg == PH_DATA) & is_read_reg & ~is_cmd_reg) begin
				miso_oe <= 1'b1;
				if (load_pending_reg) begin
					miso_out         <= rd_value[7];
					miso_shift_reg   <= {rd_value[6:0], 1'b0};
					load_pending_reg <= 1'b0;
				end else begin
					miso_out       <= miso_shift_reg[7];
					miso_shift_reg <= {miso_shift_reg[6:0], 1'b0};
				end
			end
		end
	end

	// Command source: command cycle at chip select release, or a write to 0x0f.
	always @* begin
		cmd_valid = 1'b0;
		cmd_code  = cmd_byte_reg;
		if (cs_release & cmd_have_reg) begin
			cmd_valid = 1'b1;
		end else if (host_write & (addr_reg == `ADDR_COMMAND)) begin
			cmd_valid = 1'b1;
			cmd_code  = byte_in;
		end
	end

	// Shadow copies of fields that steer the block directly.
	always @(posedge clk) begin
		if (rst | (state_reg == ST_CLEAR)) begin
			timer_clk_sel <= CLK1_DEFAULT[`TIMER_CLK_SEL_BIT];
			mask_reg      <= `ZERO_RST;
			lbt_threshold <= `ZERO_RST;
		end else if (host_write) begin
			if (addr_reg == `ADDR_CLK_CTRL1) begin
				timer_clk_sel <= byte_in[`TIMER_CLK_SEL_BIT];
			end
			if (addr_reg == `ADDR_INT_MASK0) begin
				mask_reg <= byte_in;
			end
			if (addr_reg == `ADDR_LBT_THRESH) begin
				lbt_threshold <= byte_in;
			end
		end
	end

	// Master-measured strength, loaded by the link manager only.
	always @(posedge clk) begin
		if (rst) begin
			ack_rssi_reg <= 16'h0000;
		end else if (ack_rssi_load) begin
			ack_rssi_reg <= ack_rssi_value;
		end
	end

	// Command state machine.
	always @(posedge clk) begin
		if (rst) begin
			state_reg        <= ST_CLEAR;
			sweep_reg        <= 8'h00;
			link_start       <= 1'b0;
			link_cmd         <= `LINK_WAKE;
			abort_pulse      <= 1'b0;
			pair_store       <= 1'b0;
			paired           <= 1'b0;
			rx_done_irq      <= 1'b0;
			tx_done_irq      <= 1'b0;
			info_pending_reg <= 1'b0;
		end else begin
			link_start  <= 1'b0;
			abort_pulse <= 1'b0;
			pair_store  <= 1'b0;
			rx_done_irq <= 1'b0;
			tx_done_irq <= 1'b0;
			if (cmd_valid & (cmd_code == `CMD_SEND_INFO)) begin
				info_pending_reg <= 1'b1;
			end
			if (cmd_valid & (cmd_code == `CMD_ABORT) & (state_reg != ST_CLEAR)) begin
				state_reg   <= ST_STANDBY;
				abort_pulse <= 1'b1;
			end else if (cmd_valid & (cmd_code == `CMD_REGMAP_DFLT)) begin
				state_reg <= ST_CLEAR;
				sweep_reg <= 8'h00;
			end else begin
				case (state_reg)
					ST_CLEAR: begin
						sweep_reg <= sweep_reg + 8'h01;
						if (sweep_reg == 8'hff) begin
							state_reg <= ST_STANDBY;
						end
					end
					ST_SLEEP: begin
						if (cmd_valid & (cmd_code == `CMD_HOST_WAKE)) begin
							state_reg <= ST_STANDBY;
						end
					end
					ST_STANDBY: begin
						if (cmd_valid) begin
							case (cmd_code)
								`CMD_HOST_SLEEP: state_reg <= ST_SLEEP;
								`CMD_HOST_RX:    state_reg <= ST_RX;
								`CMD_HOST_TX:    state_reg <= paired ? ST_TX : ST_STANDBY;
								`CMD_WAKE: begin
									state_reg  <= ST_LINK;
									link_start <= 1'b1;
									link_cmd   <= `LINK_WAKE;
								end
								`CMD_WAKE_CLIENT: begin
									state_reg  <= ST_LINK;
									link_start <= 1'b1;
									link_cmd   <= `LINK_WAKE_CLIENT;
								end
								`CMD_WAKE_MASTER: begin
									state_reg  <= ST_LINK;
									link_start <= 1'b1;
									link_cmd   <= `LINK_WAKE_MASTER;
								end
								`CMD_PAIR: begin
									state_reg  <= ST_LINK;
									link_start <= 1'b1;
									link_cmd   <= `LINK_PAIR;
								end
								`CMD_TEMP_PAIR: begin
									state_reg  <= ST_LINK;
									link_start <= 1'b1;
									link_cmd   <= `LINK_TEMP_PAIR;
								end
								default: state_reg <= ST_STANDBY;
							endcase
						end else if (info_pending_reg) begin
							state_reg        <= ST_LINK;
							link_start       <= 1'b1;
							link_cmd         <= `LINK_SEND_INFO;
							info_pending_reg <= 1'b0;
						end
					end
					ST_RX: begin
						if (cmd_valid & (cmd_code == `CMD_HOST_STANDBY)) begin
							state_reg <= ST_STANDBY;
						end else if (rx_complete) begin
							state_reg   <= ST_STANDBY;
							rx_done_irq <= mask_reg[`MASK_RX_READY_BIT];
						end
					end
					ST_TX: begin
						if (cmd_valid & (cmd_code == `CMD_HOST_STANDBY)) begin
							state_reg <= ST_STANDBY;
						end else if (tx_complete) begin
							state_reg   <= ST_STANDBY;
							tx_done_irq <= mask_reg[`MASK_TX_READY_BIT];
						end
					end
					ST_LINK: begin
						if (link_done) begin
							state_reg <= ST_STANDBY;
							if (link_ok & ((link_cmd == `LINK_PAIR) | (link_cmd == `LINK_TEMP_PAIR))) begin
								paired     <= 1'b1;
								pair_store <= (link_cmd == `LINK_PAIR);
							end
						end
					end
					default: state_reg <= ST_STANDBY;
				endcase
			end
		end
	end

	// Registered mode outputs derived from the current state, one clock behind it.
	always @(posedge clk) begin
		if (rst) begin
			xtal_enable  <= 1'b1;
			sleep_active <= 1'b0;
			rx_enable    <= 1'b0;
			tx_enable    <= 1'b0;
		end else begin
			xtal_enable  <= (state_reg != ST_SLEEP);
			sleep_active <= (state_reg == ST_SLEEP);
			rx_enable    <= (state_reg == ST_RX);
			tx_enable    <= (state_reg == ST_TX);
		end
	end

endmodule

`default_nettype wire

// ===== verification/serial_command_dispatch_checker.sv
// Checker for the command dispatcher: mode, event and serial-release timing.
// Assumes it is bound to the dispatcher top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module serial_command_dispatch_checker (
	// Clock and reset.
	input wire logic       clk,
	input wire logic       rst,
	// Watched ports.
	input wire logic       cs_n,
	input wire logic       miso_oe,
	input wire logic       rx_complete,
	input wire logic       tx_complete,
	input wire logic       xtal_enable,
	input wire logic       sleep_active,
	input wire logic       rx_enable,
	input wire logic       tx_enable,
	input wire logic       abort_pulse,
	input wire logic       link_start,
	input wire logic [2:0] link_cmd,
	input wire logic       pair_store,
	input wire logic       paired,
	input wire logic       rx_done_irq,
	input wire logic       tx_done_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Standby: awake with no host mode running.
	sequence s_standby;
		!rx_enable && !tx_enable && !sleep_active;
	endsequence
	sequence s_rx_done;
		rx_complete ##1 rx_done_irq;
	endsequence
	sequence s_tx_done;
		tx_complete ##1 tx_done_irq;
	endsequence

	property p_rx_irq_cause;
		rx_done_irq |-> $past(rx_complete);
	endproperty
	property p_rx_ends;
		s_rx_done |-> ##[1:2] !rx_enable;
	endproperty
	property p_tx_irq_cause;
		tx_done_irq |-> $past(tx_complete);
	endproperty
	property p_tx_ends;
		s_tx_done |-> ##[1:2] !tx_enable;
	endproperty
	property p_tx_paired;
		tx_enable |-> paired;
	endproperty
	property p_pair_commit;
		pair_store |-> link_cmd == 3'h3;
	endproperty
	property p_sleep_xtal;
		sleep_active |-> !xtal_enable;
	endproperty
	property p_abort_standby;
		abort_pulse |-> ##[1:3] s_standby;
	endproperty
	property p_miso_release;
		$rose(cs_n) |-> ##[0:6] !miso_oe;
	endproperty
	property p_link_awake;
		link_start |-> !sleep_active;
	endproperty

	a_rx_irq_cause: assert property (p_rx_irq_cause) else $error("receive event without completion");
	a_rx_ends: assert property (p_rx_ends) else $error("receive mode kept after completion");
	a_tx_irq_cause: assert property (p_tx_irq_cause) else $error("transmit event without completion");
	a_tx_ends: assert property (p_tx_ends) else $error("transmit mode kept after completion");
	a_tx_paired: assert property (p_tx_paired) else $error("transmit while unpaired");
	a_pair_commit: assert property (p_pair_commit) else $error("pairing stored for wrong operation");
	a_sleep_xtal: assert property (p_sleep_xtal) else $error("crystal on in sleep");
	a_abort_standby: assert property (p_abort_standby) else $error("abort did not reach standby");
	a_miso_release: assert property (p_miso_release) else $error("miso kept after deselect");
	a_link_awake: assert property (p_link_awake) else $error("link operation started in sleep");
endmodule

bind serial_command_dispatch serial_command_dispatch_checker i_chk (
	.clk(clk), .rst(rst), .cs_n(cs_n), .miso_oe(miso_oe), .rx_complete(rx_complete),
	.tx_complete(tx_complete), .xtal_enable(xtal_enable), .sleep_active(sleep_active),
	.rx_enable(rx_enable), .tx_enable(tx_enable), .abort_pulse(abort_pulse),
	.link_start(link_start), .link_cmd(link_cmd), .pair_store(pair_store), .paired(paired),
	.rx_done_irq(rx_done_irq), .tx_done_irq(tx_done_irq)
);
`default_nettype wire

// ===== verification/spi_host_model.sv
// Microcontroller model: serial master on chip select, clock and data.
// Assumes a free-running clk; each sclk phase spans five of its cycles.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// Reference clock and crystal state.
	input  wire logic clk,
	input  wire logic xtal_on,
	// Serial pins.
	output var  logic cs_n,
	output var  logic sclk,
	output var  logic mosi,
	input  wire logic miso
);
	// Idle pins: deselected, clock low.
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end

	// Sends n bytes of tx MSB first; rx keeps the last byte seen on miso.
	task automatic frame(input int n, input logic [23:0] tx, output logic [7:0] rx);
		int i;
		rx = 8'h00;
		@(negedge clk);
		cs_n <= 1'b0;
		for (i = 8 * n - 1; i >= 0; i--) begin
			mosi <= tx[i];
			repeat (5) @(negedge clk);
			sclk <= 1'b1;
			rx = {rx[6:0], miso};
			repeat (5) @(negedge clk);
			sclk <= 1'b0;
		end
		repeat (5) @(negedge clk);
		cs_n <= 1'b1;
		mosi <= ~mosi; // A released line keeps no stale bit.
		repeat (12) @(negedge clk);
	endtask

	// Keeps sclk idle after a wake command until the crystal runs.
	task automatic hold_for_xtal();
		int k;
		for (k = 0; k < 200 && xtal_on !== 1'b1; k++)
			@(negedge clk);
	endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the command dispatcher with a serial master model.
// Assumes the dispatcher, its checker and the master model are compiled.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [7:0] REV = 8'h5c; // Arbitrary value.
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        rx_complete = 1'b0, tx_complete = 1'b0, link_done = 1'b0, link_ok = 1'b0;
	logic        ack_rssi_load = 1'b0;
	logic [15:0] ack_rssi_value = 16'h0000;
	logic [3:0]  acs_index = 4'h0;
	logic        cs_n, sclk, mosi, miso_out, miso_oe, xtal_enable, sleep_active, timer_clk_sel;
	logic        rx_enable, tx_enable, abort_pulse, link_start, pair_store, paired;
	logic        rx_done_irq, tx_done_irq;
	logic [2:0]  link_cmd;
	logic [7:0]  lbt_threshold, acs_channel, rd;
	int          n_mismatch = 0, compares = 0;
	int          n_start = 0, n_store = 0, n_abort = 0, n_rxi = 0, n_txi = 0, s;

	// Clock at 40 MHz.
	always #12.5 clk = ~clk;

	serial_command_dispatch #(.SILICON_REVISION(REV), .CHIP_IDENT(16'h0000)) i_serial_command_dispatch (
		.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso_out(miso_out),
		.miso_oe(miso_oe), .rx_complete(rx_complete), .tx_complete(tx_complete),
		.link_done(link_done), .link_ok(link_ok), .rssi_now(8'h5a), .ack_rssi_load(ack_rssi_load),
		.ack_rssi_value(ack_rssi_value), .acs_index(acs_index), .xtal_enable(xtal_enable),
		.sleep_active(sleep_active), .timer_clk_sel(timer_clk_sel), .rx_enable(rx_enable),
		.tx_enable(tx_enable), .abort_pulse(abort_pulse), .link_start(link_start),
		.link_cmd(link_cmd), .pair_store(pair_store), .paired(paired), .rx_done_irq(rx_done_irq),
		.tx_done_irq(tx_done_irq), .lbt_threshold(lbt_threshold), .acs_channel(acs_channel)
	);
	spi_host_model host (.clk(clk), .xtal_on(xtal_enable), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso_out));

	// Counts one-cycle pulses so that no event is missed between checks.
	always @(posedge clk) begin
		n_start += int'(link_start === 1'b1);
		n_store += int'(pair_store === 1'b1);
		n_abort += int'(abort_pulse === 1'b1);
		n_rxi += int'(rx_done_irq === 1'b1);
		n_txi += int'(tx_done_irq === 1'b1);
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.frame(3, {8'h00, a, d}, rd);
	endtask
	task automatic rdreg(input logic [7:0] a);
		host.frame(3, {8'h40, a, 8'h00}, rd);
	endtask
	task automatic cmd(input logic [7:0] c);
		host.frame(2, {8'h00, 8'h80, c}, rd);
		if (c == 8'h06)
			host.hold_for_xtal();
	endtask
	// Runs one link operation and answers it with a done pulse.
	task automatic link_op(input logic [7:0] c, input logic [2:0] op, input logic ok);
		int b;
		b = n_start;
		cmd(c);
		check(n_start - b, 1);
		check(link_cmd, op);
		link_ok <= ok;
		link_done <= 1'b1;
		@(negedge clk) link_done <= 1'b0;
		repeat (4) @(negedge clk);
	endtask

	task automatic t_regs;
		rdreg(8'h00);
		check(rd, 8'h66);
		check(miso_oe, 1'b0);
		rdreg(8'h01);
		check(rd, 8'h09);
		wr(8'hff, 8'h3c);
		rdreg(8'hff);
		check(rd, REV);
		wr(8'hb0, 8'h12);
		check(lbt_threshold, 8'h12);
		rdreg(8'hb5);
		check(rd, 8'h5a);
		wr(8'h85, 8'hc7);
		acs_index <= 4'h5;
		repeat (3) @(negedge clk);
		check(acs_channel, 8'hc7);
		ack_rssi_value <= 16'hbeef;
		ack_rssi_load <= 1'b1;
		@(negedge clk) ack_rssi_load <= 1'b0;
		rdreg(8'h0b);
		check(rd, 8'hbe);
		rdreg(8'h0c);
		check(rd, 8'hef);
		wr(8'h00, 8'h64);
		check(timer_clk_sel, 1'b0);
		$display("t_regs done");
	endtask

	task automatic t_rx;
		wr(8'h04, 8'h30);
		wr(8'h0f, 8'h04);
		check(rx_enable, 1'b1);
		s = n_rxi;
		rx_complete <= 1'b1;
		@(negedge clk) rx_complete <= 1'b0;
		repeat (4) @(negedge clk);
		check(n_rxi - s, 1);
		check(rx_enable, 1'b0);
		cmd(8'h04);
		check(rx_enable, 1'b1);
		cmd(8'h03);
		check(rx_enable, 1'b0);
		check(xtal_enable, 1'b1);
		host.frame(2, {8'h00, 8'hc0, 8'h04}, rd);
		check(rx_enable, 1'b0);
		$display("t_rx done");
	endtask

	task automatic t_tx;
		wr(8'h10, 8'h21);
		cmd(8'h05);
		check(tx_enable, 1'b0);
		s = n_store;
		link_op(8'h0f, 3'h4, 1'b1);
		check(n_store - s, 0);
		check(paired, 1'b1);
		link_op(8'h0c, 3'h3, 1'b1);
		check(n_store - s, 1);
		cmd(8'h05);
		check(tx_enable, 1'b1);
		s = n_txi;
		tx_complete <= 1'b1;
		@(negedge clk) tx_complete <= 1'b0;
		repeat (4) @(negedge clk);
		check(n_txi - s, 1);
		check(tx_enable, 1'b0);
		$display("t_tx done");
	endtask

	task automatic t_link;
		link_op(8'h08, 3'h0, 1'b0);
		link_op(8'h09, 3'h1, 1'b0);
		link_op(8'h0a, 3'h2, 1'b0);
		link_op(8'h10, 3'h5, 1'b0);
		$display("t_link done");
	endtask

	task automatic t_power;
		cmd(8'h07);
		check({sleep_active, xtal_enable}, 2'b10);
		cmd(8'h05);
		check(tx_enable, 1'b0);
		cmd(8'h06);
		check({sleep_active, xtal_enable}, 2'b01);
		cmd(8'h04);
		s = n_abort;
		cmd(8'h80);
		check(n_abort - s, 1);
		check(rx_enable, 1'b0);
		s = n_start;
		cmd(8'h55);
		check(n_start - s, 0);
		check({rx_enable, tx_enable, sleep_active}, 3'b000);
		$display("t_power done");
	endtask

	task automatic t_dflt;
		cmd(8'hff);
		repeat (270) @(negedge clk);
		rdreg(8'hb0);
		check(rd, 8'h00);
		rdreg(8'h00);
		check(rd, 8'h66);
		check(timer_clk_sel, 1'b1);
		check(lbt_threshold, 8'h00);
		$display("t_dflt done");
	endtask

	task automatic conclude;
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Main sequence: reset, wait out the default sweep, then the scenarios.
	initial begin
		repeat (10) @(negedge clk);
		rst <= 1'b0;
		repeat (270) @(negedge clk);
		t_regs();
		t_rx();
		t_tx();
		t_link();
		t_power();
		t_dflt();
		conclude();
	end

	// Watchdog at about five times the expected run.
	initial begin
		#1000000;
		n_mismatch++;
		conclude();
	end
endmodule
`default_nettype wire
